// ### hw/sct_clock_control.sv
// Top of the system clock prescaler and oscillator trim block.
// Holds the trim and divide control registers behind a plain
// address/strobe port, loads strap values after reset, and produces
// the system clock enable that the CPU and peripherals run on.
// Assumes fuse and factory trim inputs are static pins from outside the
// clock domain, and that software holds strobes for one cycle each.
`timescale 1ns/1ps
`default_nettype none
`include "sct_params.svh"

// Operation
// - Factory trim loaded after reset automatically
// - Software trim write takes effect immediately
// - Top trim bit selects oscillator range
// - Low seven bits tune within range
// - Write timing scales with trim setting
// - Divide control at 0x26, bits 6:4 zero
// - Unlock only by bit 7 alone written
// - Unlock clears after four ticks or select
// - Unlock rewrite neither extends nor clears
// - Select changes only inside open window
// - Codes 0..8 divide by 1 to 256
// - Divided clock drives CPU and peripherals
// - Fuse picks reset code 0000 or 0011
// - Any code writable regardless of fuse
// - Legacy mode bypasses prescaler entirely
// - No glitch or faster intermediate frequency
// - New rate within old plus new period
module sct_clock_control #(
    parameter int NVM_WRITE_CYCLES = `SCT_NVM_WRITE_TIME_NS / `SCT_CLOCK_PERIOD_NS
) (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    output logic [7:0]      regRdData,
    input  wire logic [7:0] factoryTrim,
    input  wire logic       startDivEightFuse,
    input  wire logic       legacyModeFuse,
    input  wire logic       nvmWriteStart,
    output logic            nvmWriteBusy,
    output logic [7:0]      oscillatorTrim,
    output logic            rangeSelectBit,
    output logic [6:0]      fineTrimBits,
    output logic            sysClockTick,
    output logic [3:0]      activeDivSelect,
    output logic            divSwitching,
    output logic            unlockOpen,
    output logic            strapReady
);

    // Pin synchronisers
    logic [7:0] trimSyncA;
    logic [7:0] trimSyncB;
    logic       divFuseSyncA;
    logic       divFuseSyncB;
    logic       legacySyncA;
    logic       legacySyncB;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            trimSyncA    <= 8'h00;
            trimSyncB    <= 8'h00;
            divFuseSyncA <= 1'b0;
            divFuseSyncB <= 1'b0;
            legacySyncA  <= 1'b0;
            legacySyncB  <= 1'b0;
        end else begin
            trimSyncA    <= factoryTrim;
            trimSyncB    <= trimSyncA;
            divFuseSyncA <= startDivEightFuse;
            divFuseSyncB <= divFuseSyncA;
            legacySyncA  <= legacyModeFuse;
            legacySyncB  <= legacySyncA;
        end
    end

    // Strap capture after reset release
    sct_pkg::sct_strap_state_type strapState;
    logic [1:0]                   settleCount;
    logic                         legacyMode;
    logic                         strapLoad;
    logic [3:0]                   fuseDivCode;

    assign strapLoad   = (strapState == sct_pkg::STRAP_LOAD);
    assign strapReady  = (strapState == sct_pkg::STRAP_RUN);
    // Fuse chooses the reset divide code
    assign fuseDivCode = divFuseSyncB ? `SCT_DIV_RESET_EIGHT : `SCT_DIV_RESET_PLAIN;

    // Straps need the synchroniser to fill before they are trusted
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            strapState  <= sct_pkg::STRAP_SETTLE;
            settleCount <= 2'h0;
            legacyMode  <= 1'b0;
        end else begin
            case (strapState)
                sct_pkg::STRAP_SETTLE: begin
                    settleCount <= settleCount + 2'h1;
                    if (settleCount == `SCT_STRAP_SETTLE) begin
                        strapState <= sct_pkg::STRAP_LOAD;
                    end
                end
                sct_pkg::STRAP_LOAD: begin
                    legacyMode <= legacySyncB;
                    strapState <= sct_pkg::STRAP_RUN;
                end
                sct_pkg::STRAP_RUN: begin
                    strapState <= sct_pkg::STRAP_RUN;
                end
                default: begin
                    strapState <= sct_pkg::STRAP_SETTLE;
                end
            endcase
        end
    end

    // Register decode
    logic       hitDivCtrl;
    logic       hitTrim;
    logic       writeDivCtrl;
    logic       writeTrim;
    logic       unlockPattern;
    logic       unlockWrite;
    logic       selectWrite;
    logic [3:0] writeSelect;
    logic       selectLegal;

    function automatic logic code_is_legal(input logic [3:0] code);
        code_is_legal = (code <= `SCT_DIV_MAX_CODE);
    endfunction

    assign hitDivCtrl    = (regAddr == `SCT_ADDR_DIV_CTRL);
    assign hitTrim       = (regAddr == `SCT_ADDR_OSC_TRIM);
    // Writes before the straps settle would be overwritten anyway
    assign writeDivCtrl  = regWrite & hitDivCtrl & strapReady;
    assign writeTrim     = regWrite & hitTrim & strapReady;
    assign writeSelect   = regWrData[`SCT_SELECT_MSB:`SCT_SELECT_LSB];
    // Unlock bit alone, every other bit zero
    assign unlockPattern = (regWrData == (8'h01 << `SCT_UNLOCK_BIT));
    assign unlockWrite   = writeDivCtrl & unlockPattern & ~legacyMode;
    // Select write needs bit 7 low and an open window
    assign selectWrite   = writeDivCtrl & ~regWrData[`SCT_UNLOCK_BIT]
                         & unlockOpen & ~legacyMode;
    // Reserved codes are stored but never reach the divider
    assign selectLegal   = code_is_legal(writeSelect);

    // Unlock window
    sct_unlock_window u_unlock (
        .clock       (clock),
        .rst         (rst),
        .tick        (sysClockTick),
        .unlockWrite (unlockWrite),
        .selectWrite (selectWrite),
        .windowOpen  (unlockOpen)
    );

    // Divide select register
    logic [3:0] divSelect;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            divSelect <= `SCT_DIV_RESET_PLAIN;
        end else if (strapLoad) begin
            divSelect <= fuseDivCode;
        // Any code accepted whatever the fuse
        end else if (selectWrite) begin
            divSelect <= writeSelect;
        end
    end

    // Prescaler
    logic prescalerRequest;

    assign prescalerRequest = selectWrite & selectLegal;

    // Tick is the enable for CPU and peripherals
    sct_prescaler u_prescaler (
        .clock       (clock),
        .rst         (rst),
        .init        (strapLoad),
        .initCode    (fuseDivCode),
        .request     (prescalerRequest),
        .requestCode (writeSelect),
        .bypass      (legacyMode),
        .tick        (sysClockTick),
        .activeCode  (activeDivSelect),
        .switching   (divSwitching)
    );

    // Oscillator trim register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            oscillatorTrim <= `SCT_TRIM_RESET;
        // Factory value taken once straps are stable
        end else if (strapLoad) begin
            oscillatorTrim <= trimSyncB;
        // Software write drives oscillator at once
        end else if (writeTrim) begin
            oscillatorTrim <= regWrData;
        end
    end

    assign rangeSelectBit = oscillatorTrim[`SCT_RANGE_BIT];
    // Fine tune bits to the oscillator
    assign fineTrimBits   = oscillatorTrim[`SCT_RANGE_BIT-1:0];

    // Nonvolatile write timer on raw oscillator cycles
    sct_pkg::sct_nvm_state_type nvmState;
    logic [31:0]                nvmCount;

    assign nvmWriteBusy = (nvmState == sct_pkg::NVM_BUSY);

    // Counts oscillator cycles, so duration follows trim
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            nvmState <= sct_pkg::NVM_IDLE;
            nvmCount <= 32'h0;
        end else begin
            case (nvmState)
                sct_pkg::NVM_IDLE: begin
                    nvmCount <= 32'h0;
                    if (nvmWriteStart) begin
                        nvmState <= sct_pkg::NVM_BUSY;
                    end
                end
                sct_pkg::NVM_BUSY: begin
                    nvmCount <= nvmCount + 32'h1;
                    if (nvmCount >= 32'(NVM_WRITE_CYCLES - 1)) begin
                        nvmState <= sct_pkg::NVM_IDLE;
                    end
                end
                default: begin
                    nvmState <= sct_pkg::NVM_IDLE;
                end
            endcase
        end
    end

    // Read path
    logic [7:0] divCtrlView;
    logic [7:0] readMux;

    // Reserved bits read zero, writes ignored
    assign divCtrlView = {unlockOpen, 3'h0, divSelect};
    assign readMux     = hitDivCtrl ? divCtrlView :
                         hitTrim    ? oscillatorTrim : 8'h00;

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            regRdData <= 8'h00;
        end else if (regRead) begin
            regRdData <= readMux;
        end else begin
            regRdData <= 8'h00;
        end
    end

endmodule
`default_nettype wire

// ### hw/sct_params.svh
// Constants for the system clock prescaler and oscillator trim block.
// Assumes a single 100 MHz master clock and an 8-bit register port.
`ifndef SCT_PARAMS_SVH
`define SCT_PARAMS_SVH

`define SCT_ADDR_DIV_CTRL     8'h26
`define SCT_ADDR_OSC_TRIM     8'h27
`define SCT_UNLOCK_BIT        7
`define SCT_RANGE_BIT         7
`define SCT_RES_MSB           6
`define SCT_RES_LSB           4
`define SCT_SELECT_MSB        3
`define SCT_SELECT_LSB        0
`define SCT_DIV_RESET_PLAIN   4'h0
`define SCT_DIV_RESET_EIGHT   4'h3
`define SCT_DIV_MAX_CODE      4'h8
`define SCT_TRIM_RESET        8'h00
`define SCT_UNLOCK_LAST       3'h3
`define SCT_STRAP_SETTLE      2'h3
`define SCT_CLOCK_PERIOD_NS   10
`define SCT_NVM_WRITE_TIME_NS 3400000

`endif

// ### hw/sct_pkg.sv
// Types shared by the prescaler and trim block.
// Constants live in sct_params.svh.
package sct_pkg;

    typedef enum logic [0:0] {
        UNLOCK_CLOSED,
        UNLOCK_OPEN
    } sct_unlock_state_type;

    typedef enum logic [1:0] {
        STRAP_SETTLE,
        STRAP_LOAD,
        STRAP_RUN
    } sct_strap_state_type;

    typedef enum logic [0:0] {
        NVM_IDLE,
        NVM_BUSY
    } sct_nvm_state_type;

endpackage

// ### hw/sct_prescaler.sv
// Glitch-free power-of-two system clock prescaler.
// Assumes requests come from the register logic on the same master clock.
`timescale 1ns/1ps
`default_nettype none
`include "sct_params.svh"

module sct_prescaler (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       init,
    input  wire logic [3:0] initCode,
    input  wire logic       request,
    input  wire logic [3:0] requestCode,
    input  wire logic       bypass,
    output logic            tick,
    output logic [3:0]      activeCode,
    output logic            switching
);

    logic [7:0] divCount;
    logic [3:0] pendingCode;
    logic       pending;
    logic [7:0] divMask;
    logic       applyNow;

    function automatic logic [7:0] mask_of(input logic [3:0] code);
        logic [8:0] full;
        full    = 9'h001 << code;
        mask_of = 8'(full - 9'h001);
    endfunction

    assign divMask   = mask_of(activeCode);
    assign tick      = bypass | ((divCount & divMask) == divMask);
    assign switching = pending;
    // Switch only on an old-period boundary
    assign applyNow  = pending & tick & ~bypass;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            divCount    <= 8'h00;
            activeCode  <= `SCT_DIV_RESET_PLAIN;
            pendingCode <= `SCT_DIV_RESET_PLAIN;
            pending     <= 1'b0;
        end else if (init) begin
            divCount   <= 8'h00;
            activeCode <= initCode;
            pending    <= 1'b0;
        end else begin
            // Old period ends, new one starts from zero
            if (applyNow) begin
                activeCode <= pendingCode;
                divCount   <= 8'h00;
                pending    <= 1'b0;
            end else begin
                divCount <= divCount + 8'h01;
            end
            if (request) begin
                pendingCode <= requestCode;
                pending     <= 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

// ### hw/sct_unlock_window.sv
// Unlock window for divide select changes.
// Assumes tick is the one-cycle system clock enable from the prescaler.
`timescale 1ns/1ps
`default_nettype none
`include "sct_params.svh"

module sct_unlock_window (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic tick,
    input  wire logic unlockWrite,
    input  wire logic selectWrite,
    output logic      windowOpen
);

    sct_pkg::sct_unlock_state_type state;
    logic [2:0]                    tickCount;

    assign windowOpen = (state == sct_pkg::UNLOCK_OPEN);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state     <= sct_pkg::UNLOCK_CLOSED;
            tickCount <= 3'h0;
        end else begin
            case (state)
                sct_pkg::UNLOCK_CLOSED: begin
                    tickCount <= 3'h0;
                    if (unlockWrite) begin
                        state <= sct_pkg::UNLOCK_OPEN;
                    end
                end
                sct_pkg::UNLOCK_OPEN: begin
                    if (selectWrite) begin
                        state <= sct_pkg::UNLOCK_CLOSED;
                    end else if (tick) begin
                        if (tickCount == `SCT_UNLOCK_LAST) begin
                            state <= sct_pkg::UNLOCK_CLOSED;
                        end
                        tickCount <= tickCount + 3'h1;
                    end
                end
                default: begin
                    state <= sct_pkg::UNLOCK_CLOSED;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// ### sim/sct_clock_control_assertions.sv
// Checker for the clock control top: register port, unlock window, tick spacing.
// Assumes it is bound onto sct_clock_control and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
`include "sct_params.svh"

module sct_clock_control_assertions (
    input wire logic       clock,
    input wire logic       rst,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic       regWrite,
    input wire logic       regRead,
    input wire logic [7:0] regRdData,
    input wire logic [7:0] factoryTrim,
    input wire logic       startDivEightFuse,
    input wire logic       legacyModeFuse,
    input wire logic [7:0] oscillatorTrim,
    input wire logic       rangeSelectBit,
    input wire logic [6:0] fineTrimBits,
    input wire logic       sysClockTick,
    input wire logic [3:0] activeDivSelect,
    input wire logic       divSwitching,
    input wire logic       unlockOpen,
    input wire logic       strapReady
);
    logic [2:0] winTicks;
    logic [8:0] gap;
    logic       gapOk;
    wire        ctlWr = regWrite && strapReady && regAddr == `SCT_ADDR_DIV_CTRL;

    // Ticks seen while open; a rewrite must not clear this count
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            winTicks <= 3'h0;
            gap      <= 9'h1;
            gapOk    <= 1'b0;
        end else begin
            winTicks <= !unlockOpen ? 3'h0 : winTicks + {2'h0, sysClockTick};
            gap      <= sysClockTick ? 9'h1 : gap + 9'h1;
            gapOk    <= gapOk || (sysClockTick && strapReady);
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    a_factory_trim_load: assert property ($rose(strapReady) |-> oscillatorTrim == factoryTrim)
        else $error("trim not loaded from factory value");
    a_trim_write_apply: assert property (regWrite && strapReady &&
        regAddr == `SCT_ADDR_OSC_TRIM |=> oscillatorTrim == $past(regWrData))
        else $error("trim write not applied");
    a_trim_field_split: assert property ({rangeSelectBit, fineTrimBits} == oscillatorTrim)
        else $error("trim fields wrong");
    a_reserved_read_zero: assert property (regRead && regAddr == `SCT_ADDR_DIV_CTRL
        |=> regRdData[6:4] == 3'h0)
        else $error("reserved bits not zero");
    a_read_idle_zero: assert property (!$past(regRead) |-> regRdData == 8'h00)
        else $error("read data outside read cycle");
    a_unlock_open: assert property (ctlWr && regWrData == 8'h80 && !unlockOpen &&
        !legacyModeFuse |=> unlockOpen)
        else $error("clean unlock write did not open");
    a_unlock_dirty: assert property (ctlWr && regWrData[7] && regWrData[6:0] != 7'h0 &&
        !unlockOpen |=> !unlockOpen)
        else $error("dirty unlock write opened");
    a_window_limit: assert property (unlockOpen |-> winTicks < 3'h4)
        else $error("window open past four ticks");
    a_window_hold: assert property (unlockOpen && !(sysClockTick && winTicks == 3'h3) &&
        !(ctlWr && !regWrData[7]) |=> unlockOpen)
        else $error("window closed early");
    a_select_close: assert property (ctlWr && !regWrData[7] && unlockOpen &&
        regWrData[3:0] <= 4'h8 |=> !unlockOpen && divSwitching)
        else $error("select write not taken");
    a_locked_select: assert property (!unlockOpen && !divSwitching |=> !divSwitching)
        else $error("divider switched without window");
    a_switch_bound: assert property ($rose(divSwitching) |->
        ##[0:256] (sysClockTick && divSwitching) ##1 !divSwitching)
        else $error("switch not done within old period");
    a_code_on_tick: assert property ($changed(activeDivSelect) && $past(strapReady) |->
        $past(divSwitching) && $past(sysClockTick))
        else $error("code changed mid period");
    a_tick_spacing: assert property (sysClockTick && gapOk && !legacyModeFuse |->
        gap == (9'h1 << activeDivSelect))
        else $error("tick spacing wrong");
    a_fuse_reset_code: assert property ($rose(strapReady) && !legacyModeFuse |->
        activeDivSelect == (startDivEightFuse ? 4'h3 : 4'h0))
        else $error("reset code wrong");
    a_legacy_bypass: assert property (strapReady && legacyModeFuse |->
        sysClockTick && !unlockOpen)
        else $error("legacy mode not bypassed");
endmodule

bind sct_clock_control sct_clock_control_assertions u_chk (.*);

`default_nettype wire

// ### sim/tb.sv
// Self-checking bench for the clock control top with a small register model.
// Assumes the design files and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
`include "sct_params.svh"

module tb;
    localparam logic [7:0] CTL = `SCT_ADDR_DIV_CTRL;
    localparam logic [7:0] TRM = `SCT_ADDR_OSC_TRIM;
    logic       clock;
    logic       rst;
    logic [7:0] regAddr;
    logic [7:0] regWrData;
    logic       regWrite;
    logic       regRead;
    logic [7:0] regRdData;
    logic [7:0] factoryTrim;
    logic       startDivEightFuse;
    logic       legacyModeFuse;
    logic       nvmWriteStart;
    logic       nvmWriteBusy;
    logic [7:0] oscillatorTrim;
    logic       rangeSelectBit;
    logic [6:0] fineTrimBits;
    logic       sysClockTick;
    logic [3:0] activeDivSelect;
    logic       divSwitching;
    logic       unlockOpen;
    logic       strapReady;
    logic [7:0] lf;
    logic [7:0] trm;
    int         error_cnt;
    int         num_checks;
    int         cyc;
    int         mSel;
    int         mAct;
    int         k;

    // Short write timer keeps the run brief
    sct_clock_control #(.NVM_WRITE_CYCLES(20)) dut (.*);

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            error_cnt++;
            wrap_up();
        end
    end

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        regAddr   <= a;
        regWrData <= d;
        regWrite  <= 1'b1;
        @(posedge clock);
        regWrite  <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        #1;
        chk({1'b0, regRdData}, {1'b0, e});
    endtask

    // Fuses and trim pins settle while reset is held
    task automatic boot(input logic fuse, input logic legacy);
        int n;
        @(posedge clock);
        lf = lfsr(lf);
        rst               <= 1'b1;
        factoryTrim       <= lf;
        startDivEightFuse <= fuse;
        legacyModeFuse    <= legacy;
        mSel = fuse ? 3 : 0;
        mAct = mSel;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        n = 0;
        do begin
            @(posedge clock);
            #1;
            n++;
        end while (strapReady !== 1'b1 && n < 20);
        rd(TRM, lf);
        if (!legacy) rd(CTL, 8'(mSel));
    endtask

    // Counts master cycles between two ticks; the first tick found is the start
    task automatic gapchk(input int e);
        int n;
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (sysClockTick !== 1'b1 && n < 600);
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (sysClockTick !== 1'b1 && n < 600);
        chk(9'(n), 9'(e));
    endtask

    task automatic setdiv(input logic [7:0] d);
        wr(CTL, 8'h80);
        wr(CTL, d);
        mSel = int'(d[3:0]);
        if (d[3:0] <= 4'h8) mAct = mSel;
    endtask

    task automatic wrap_up();
        if (error_cnt == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        rst = 1'b1;
        regAddr = 8'h00;
        regWrData = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
        factoryTrim = 8'h00;
        startDivEightFuse = 1'b0;
        legacyModeFuse = 1'b0;
        nvmWriteStart = 1'b0;
        lf = 8'h17;
        boot(1'b1, 1'b0);
        gapchk(8);
        trm = lf;
        for (k = 0; k < 8; k++) begin
            lf = lfsr(lf);
            trm = trm[7] ? trm - {3'h0, lf[4:0]} : trm + {3'h0, lf[4:0]};
            wr(TRM, trm);
            chk({1'b0, oscillatorTrim}, {1'b0, trm});
            chk({1'b0, rangeSelectBit, fineTrimBits}, {1'b0, trm});
            rd(TRM, trm);
        end
        wr(8'h25, 8'hff);
        rd(8'h25, 8'h00);
        rd(TRM, trm);
        wr(CTL, 8'h05);
        rd(CTL, 8'(mSel));
        wr(CTL, 8'h81);
        rd(CTL, 8'(mSel));
        wr(CTL, 8'h02);
        rd(CTL, 8'(mSel));
        wr(CTL, 8'h80);
        rd(CTL, 8'h80 | 8'(mSel));
        repeat (300) @(posedge clock);
        wr(CTL, 8'h01);
        rd(CTL, 8'(mSel));
        wr(CTL, 8'h80);
        setdiv(8'h72);
        rd(CTL, 8'(mSel));
        for (k = 0; k < 16; k++) begin
            setdiv(8'h70 | 8'(k));
            rd(CTL, 8'(mSel));
            gapchk(1 << mAct);
            chk({5'h0, activeDivSelect}, 9'(mAct));
        end
        @(posedge clock);
        nvmWriteStart <= 1'b1;
        @(posedge clock);
        nvmWriteStart <= 1'b0;
        repeat (19) @(posedge clock);
        #1;
        chk({8'h0, nvmWriteBusy}, 9'h1);
        @(posedge clock);
        #1;
        chk({8'h0, nvmWriteBusy}, 9'h0);
        boot(1'b0, 1'b0);
        gapchk(1);
        boot(1'b1, 1'b1);
        setdiv(8'h05);
        chk({8'h0, unlockOpen}, 9'h0);
        gapchk(1);
        wrap_up();
    end
endmodule

`default_nettype wire
